// ==== core/autocfg_params.svh ====
// constants for the isa auto-configuration port trio
// assumes a 12-bit isa i/o decode and 8-bit configuration registers
`ifndef AUTOCFG_PARAMS_SVH
`define AUTOCFG_PARAMS_SVH
`define ACFG_INDEX_PORT   12'h279
`define ACFG_WRITE_PORT   12'hA79
`define ACFG_RDPORT_LOW   2'h3
`define ACFG_REG_RDPORT   8'h00
`define ACFG_REG_ISOLATE  8'h01
`define ACFG_REG_CONTROL  8'h02
`define ACFG_CTL_WAITKEY  1
`define ACFG_REG_ACTIVATE 8'h30
`define ACFG_ISO_FIRST    8'h55
`define ACFG_ISO_SECOND   8'hAA
`define ACFG_ID_BITS      7'h48
`define ACFG_KEY_SEED     8'h01
`define ACFG_KEY_LEN      6'h20
`endif

// ==== core/autocfg_pkg.sv ====
// types shared by the auto-configuration port logic
// assumes the constants header is included alongside
package autocfg_pkg;
	typedef enum logic [1:0]
	{
		ST_WAIT_KEY = 2'b01,
		ST_CONFIG   = 2'b10
	} cfg_state_t;

	typedef struct packed
	{
		logic [11:0] addr;
		logic [7:0]  data;
	} isa_cycle_t;
endpackage

// ==== core/isa_autoconfig_ports.sv ====
// isa auto-configuration ports: index, write-data alias, relocatable read-data
// assumes isa strobes and buses arrive asynchronous; register file on i_clk_sys
//
// Summary of operation
// - The index port is decoded as a write-only byte at i/o 0x279.
// - The write-data port is decoded as a write-only byte at i/o 0xA79.
// - The read-data port sits at a location from 0x203 to 0x3FF set by a write command.
// - All three ports match on the low 12 address bits only.
// - The configuration space is a set of 8-bit registers reached by index.
// - The last index written is held for any number of data accesses.
// - A write-data byte goes to the register selected by the held index.
// - A read-data read returns the register selected by the held index.
// - Writing register 0 sets where read-data reads are decoded.
// - Writes to the index port are watched for the unlock key pattern.
// - After reset the device is active when it boots from network, else inactive.
// - The active flag is only driven out; the ports answer accesses whether or not it is set.
// - The key needs consecutive matching index writes; any other access to the index port restarts it.
// - In isolation a one bit drives 0x55 then 0xAA over a read pair; a zero floats.
// - Serial data is shifted out least significant bit first.
`include "autocfg_params.svh"
module isa_autoconfig_ports
	import autocfg_pkg::*;
#(
	parameter logic [7:0] KEY_SEED = `ACFG_KEY_SEED,
	parameter logic [5:0] KEY_LEN  = `ACFG_KEY_LEN
)
(
	input  wire logic        i_clk_sys,       // device clock
	input  wire logic        i_nrst,          // async reset, active low
	input  wire logic [11:0] i_sa,            // isa address, low 12 bits
	input  wire logic [7:0]  i_sd,            // isa data in
	input  wire logic        i_iow_n,         // isa i/o write, active low
	input  wire logic        i_ior_n,         // isa i/o read, active low
	input  wire logic        i_boot_from_net, // strap: boot from network
	input  wire logic [71:0] i_serial_id,     // serial identifier
	input  wire logic [7:0]  i_reg_rdata,     // selected register contents
	output logic      [7:0]  o_sd,            // isa data out
	output logic             o_sd_oe,         // isa data drive enable
	output logic      [7:0]  o_reg_index,     // held register index
	output logic      [7:0]  o_reg_wdata,     // register write data
	output logic             o_reg_wr,        // register write pulse
	output logic             o_dev_active,    // device may answer and request
	output logic             o_cfg_mode       // configuration mode
);
	isa_cycle_t  cyc_s1;
	isa_cycle_t  cyc_s2;
	logic [1:0]  iow_s;
	logic [1:0]  ior_s;
	logic        iow_q;
	logic        ior_q;
	logic        wr_done;
	logic        rd_start;
	logic        rd_end;
	cfg_state_t  state;
	logic [7:0]  rd_base;
	logic [7:0]  key_lfsr;
	logic [5:0]  key_cnt;
	logic [2:0]  boot_seen;
	logic [1:0]  strap_s;
	logic        iso_second;
	logic [6:0]  bit_ptr;
	logic        hit_index;
	logic        hit_write;
	logic        hit_read;
	logic        iso_sel;

	function automatic logic [7:0] lfsr_step(input logic [7:0] v);
		lfsr_step = {v[0] ^ v[1], v[7:1]};
	endfunction

	// two flops on every isa bus and strobe pin before any logic looks at it
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cyc_s1 <= '0;
			cyc_s2 <= '0;
			iow_s  <= 2'h3;
			ior_s  <= 2'h3;
			iow_q  <= 1'b1;
			ior_q  <= 1'b1;
		end
		else
		begin
			cyc_s1 <= '{addr: i_sa, data: i_sd};
			cyc_s2 <= cyc_s1;
			iow_s  <= {iow_s[0], i_iow_n};
			ior_s  <= {ior_s[0], i_ior_n};
			iow_q  <= iow_s[1];
			ior_q  <= ior_s[1];
		end
	end

	// write data is taken at the strobe's trailing edge, when it is surely settled
	assign wr_done  = iow_s[1] & ~iow_q;
	assign rd_start = ~ior_s[1] & ior_q;
	assign rd_end   = ior_s[1] & ~ior_q;

	assign hit_index = cyc_s2.addr == `ACFG_INDEX_PORT;
	assign hit_write = cyc_s2.addr == `ACFG_WRITE_PORT;
	// relocated read port, only inside its legal range
	assign hit_read  = rd_base[7] && cyc_s2.addr == {2'h0, rd_base, `ACFG_RDPORT_LOW};
	assign iso_sel   = o_reg_index == `ACFG_REG_ISOLATE;

	// strap is a pin: synchronised, then taken once both flops have filled
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			{boot_seen, strap_s} <= '0;
		else
			{boot_seen, strap_s} <= {boot_seen[1:0], 1'b1, strap_s[0], i_boot_from_net};
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			o_dev_active <= 1'b0;
		else if (!boot_seen[2])
			o_dev_active <= strap_s[1];
		else if (state == ST_CONFIG && wr_done && hit_write
			&& o_reg_index == `ACFG_REG_ACTIVATE)
			o_dev_active <= cyc_s2.data[0];
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			key_lfsr <= KEY_SEED;
			key_cnt  <= '0;
		end
		else if (state != ST_WAIT_KEY)
		begin
			key_lfsr <= KEY_SEED;
			key_cnt  <= '0;
		end
		else if (wr_done && hit_index && cyc_s2.data == key_lfsr)
		begin
			key_lfsr <= lfsr_step(key_lfsr);
			key_cnt  <= key_cnt + 6'h1;
		end
		// any other access to the index port restarts the key
		else if ((wr_done || rd_start) && hit_index)
		begin
			key_lfsr <= KEY_SEED;
			key_cnt  <= '0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			state <= ST_WAIT_KEY;
		else
			case (state)
				ST_WAIT_KEY:
					if (wr_done && hit_index && cyc_s2.data == key_lfsr
						&& key_cnt == KEY_LEN - 6'h1)
						state <= ST_CONFIG;
				ST_CONFIG:
					if (wr_done && hit_write && o_reg_index == `ACFG_REG_CONTROL
						&& cyc_s2.data[`ACFG_CTL_WAITKEY])
						state <= ST_WAIT_KEY;
				default:
					state <= ST_WAIT_KEY;
			endcase
	end

	assign o_cfg_mode = state[1]; // one-hot: the config state flop itself

	// index held until the next index write
	// byte write routed to the held index
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_reg_index <= '0;
			o_reg_wdata <= '0;
			o_reg_wr    <= 1'b0;
		end
		else
		begin
			o_reg_wr <= 1'b0;
			if (state == ST_CONFIG && wr_done && hit_index)
				o_reg_index <= cyc_s2.data;
			if (state == ST_CONFIG && wr_done && hit_write)
			begin
				o_reg_wdata <= cyc_s2.data;
				o_reg_wr    <= 1'b1;
			end
		end
	end

	// register 0 moves the read port
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
			rd_base <= '0;
		else if (state == ST_CONFIG && wr_done && hit_write
			&& o_reg_index == `ACFG_REG_RDPORT)
			rd_base <= cyc_s2.data;
	end

	// identifier walked lsb first, one bit per read pair
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			iso_second <= 1'b0;
			bit_ptr    <= '0;
		end
		else if (state != ST_CONFIG || !iso_sel)
		begin
			iso_second <= 1'b0;
			bit_ptr    <= '0;
		end
		else if (rd_end && hit_read)
		begin
			iso_second <= ~iso_second;
			if (iso_second)
				bit_ptr <= (bit_ptr == `ACFG_ID_BITS - 7'h1) ? 7'h0 : bit_ptr + 7'h1;
		end
	end

	// read port returns the selected register
	// isolation answers 0x55/0xAA for a one, floats for a zero
	always_ff @(posedge i_clk_sys or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_sd    <= '0;
			o_sd_oe <= 1'b0;
		end
		else if (rd_end || state != ST_CONFIG)
			o_sd_oe <= 1'b0;
		else if (rd_start && hit_read)
		begin
			if (iso_sel)
			begin
				o_sd    <= iso_second ? `ACFG_ISO_SECOND : `ACFG_ISO_FIRST;
				o_sd_oe <= i_serial_id[bit_ptr];
			end
			else
			begin
				o_sd    <= i_reg_rdata;
				o_sd_oe <= 1'b1;
			end
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	chk_key_unlock: assert property (
		$rose(o_cfg_mode) |-> $past(wr_done && hit_index && key_cnt == KEY_LEN - 6'h1))
		else $error("config mode entered without full key");
	chk_key_restart: assert property (
		state == ST_WAIT_KEY && rd_start && hit_index |=> key_cnt == 6'h0)
		else $error("key checker not restarted by index read");
	chk_index_hold: assert property (
		!(wr_done && hit_index) |=> $stable(o_reg_index))
		else $error("index changed without index write");
	chk_write_route: assert property (
		o_cfg_mode && wr_done && hit_write |=> o_reg_wr && o_reg_wdata == $past(cyc_s2.data))
		else $error("data write not delivered");
	chk_write_only_cfg: assert property (
		o_reg_wr |-> $past(o_cfg_mode && wr_done && hit_write))
		else $error("spurious register write");
	chk_read_data: assert property (
		o_cfg_mode && rd_start && hit_read && !iso_sel |=> o_sd_oe && o_sd == $past(i_reg_rdata))
		else $error("read port returned wrong data");
	chk_read_float: assert property (
		o_sd_oe |-> o_cfg_mode)
		else $error("data driven outside config mode");
	chk_port_move: assert property (
		o_cfg_mode && wr_done && hit_write && o_reg_index == 8'h00
		|=> rd_base == $past(cyc_s2.data))
		else $error("read port not relocated");
	chk_iso_pair: assert property (
		o_cfg_mode && iso_sel && rd_start && hit_read && i_serial_id[bit_ptr]
		|=> o_sd == (iso_second ? 8'hAA : 8'h55) && o_sd_oe)
		else $error("isolation pattern wrong");
	chk_bit_order: assert property (
		o_cfg_mode && iso_sel && rd_end && hit_read && iso_second && bit_ptr < 7'h47
		|=> bit_ptr == $past(bit_ptr) + 7'h1)
		else $error("serial bit not advanced lsb first");

	cov_unlock: cover property ($rose(o_cfg_mode));
	cov_reg_read: cover property (o_sd_oe && !iso_sel);
	cov_iso_drive: cover property (o_sd_oe && iso_sel && o_sd == 8'hAA);
	cov_relocate: cover property (o_reg_wr && o_reg_index == 8'h00);
endmodule

// ==== bench/cfg_reg_model.sv ====
// behavioural register file that sits behind the configuration ports
// assumes index, write data and write pulse come from the port block on i_clk_sys
module cfg_reg_model
(
	input  wire logic       i_clk_sys, // device clock
	input  wire logic [7:0] i_index,   // selected register
	input  wire logic [7:0] i_wdata,   // write data
	input  wire logic       i_wr,      // write pulse
	output logic      [7:0] o_rdata    // selected contents
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [256];
	initial
	begin
		foreach (regs[k])
			regs[k] = 8'h00;
	end
	always @(posedge i_clk_sys)
	begin
		if (i_wr === 1'b1)
			regs[i_index] <= i_wdata;
	end
	assign o_rdata = regs[i_index];
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the auto-configuration ports, host cycles by tasks
// assumes the register model answers reads combinationally from the index
`include "autocfg_params.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, iow_n, ior_n, strap, oe, wr, active, cfgm, rd_oe;
	logic [11:0] sa;
	logic [7:0]  sd, rsd, idx, wdat, rdat, rd_val;
	logic [71:0] sid;
	int          num_errors, comparisons, cycles, wr_count;

	isa_autoconfig_ports DUT (.i_clk_sys(clk), .i_nrst(nrst), .i_sa(sa), .i_sd(sd),
		.i_iow_n(iow_n), .i_ior_n(ior_n), .i_boot_from_net(strap), .i_serial_id(sid),
		.i_reg_rdata(rdat), .o_sd(rsd), .o_sd_oe(oe), .o_reg_index(idx),
		.o_reg_wdata(wdat), .o_reg_wr(wr), .o_dev_active(active), .o_cfg_mode(cfgm));
	cfg_reg_model partner (.i_clk_sys(clk), .i_index(idx), .i_wdata(wdat), .i_wr(wr),
		.o_rdata(rdat));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic end_sim;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a hung handshake must not stall the run forever
	always @(posedge clk)
	begin
		cycles++;
		if (wr === 1'b1)
			wr_count++;
		if (cycles == 6000)
		begin
			num_errors++;
			end_sim();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// address and data held well past the strobe, the port samples late
	task automatic io_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		sa = a;
		sd = d;
		iow_n = 1'b0;
		repeat (5) @(posedge clk);
		#1 iow_n = 1'b1;
		repeat (5) @(posedge clk);
		#1 sd = ~d;
	endtask

	task automatic io_rd(input logic [11:0] a);
		@(posedge clk) #1;
		sa = a;
		ior_n = 1'b0;
		repeat (6) @(posedge clk);
		#1 rd_val = rsd;
		rd_oe = oe;
		ior_n = 1'b1;
		repeat (6) @(posedge clk);
	endtask

	// writes key values first .. first+n-1 of the sequence that starts at the seed
	task automatic key(input int first, input int n);
		logic [7:0] v;
		v = `ACFG_KEY_SEED;
		for (int i = 0; i < first + n; i++)
		begin
			if (i >= first)
				io_wr(`ACFG_INDEX_PORT, v);
			v = {v[0] ^ v[1], v[7:1]};
		end
	endtask

	task automatic cfg(input logic [7:0] r, input logic [7:0] d);
		io_wr(`ACFG_INDEX_PORT, r);
		io_wr(`ACFG_WRITE_PORT, d);
	endtask

	initial
	begin
		{nrst, strap, sa, sd, cycles, num_errors, comparisons, wr_count} = '0;
		{iow_n, ior_n} = 2'b11;
		sid = 72'h00_0000_0000_0000_0001;
		repeat (12) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(8'(active), 8'h00);
		io_wr(`ACFG_WRITE_PORT, 8'h5A);
		check(8'(wr_count), 8'h00);
		// a bad write must restart the checker, else the last key value would unlock
		key(0, 31);
		io_wr(`ACFG_INDEX_PORT, 8'h00);
		key(31, 1);
		check(8'(cfgm), 8'h00);
		key(0, 31);
		io_rd(`ACFG_INDEX_PORT);
		key(31, 1);
		check(8'(cfgm), 8'h00);
		key(0, 32);
		check(8'(cfgm), 8'h01);
		cfg(8'h05, 8'h3C);
		check(idx, 8'h05);
		check(partner.regs[5], 8'h3C);
		io_wr(`ACFG_WRITE_PORT, 8'h4D);
		check(partner.regs[5], 8'h4D);
		io_rd(12'h20F);
		check(8'(rd_oe), 8'h00);
		cfg(8'h00, 8'h83);
		io_wr(`ACFG_INDEX_PORT, 8'h05);
		io_rd(12'h20F);
		check(8'(rd_oe), 8'h01);
		check(rd_val, 8'h4D);
		cfg(8'h00, 8'hFF);
		io_wr(`ACFG_INDEX_PORT, 8'h05);
		io_rd(12'h3FF);
		check(rd_val, 8'h4D);
		io_rd(12'h20F);
		check(8'(rd_oe), 8'h00);
		io_wr(`ACFG_INDEX_PORT, 8'h01);
		io_rd(12'h3FF);
		check(rd_val, `ACFG_ISO_FIRST);
		io_rd(12'h3FF);
		check(rd_val, `ACFG_ISO_SECOND);
		io_rd(12'h3FF);
		check(8'(rd_oe), 8'h00);
		io_rd(12'h3FF);
		check(8'(rd_oe), 8'h00);
		cfg(`ACFG_REG_ACTIVATE, 8'h01);
		check(8'(active), 8'h01);
		cfg(`ACFG_REG_CONTROL, 8'h02);
		check(8'(cfgm), 8'h00);
		io_rd(12'h3FF);
		check(8'(rd_oe), 8'h00);
		#1 nrst = 1'b0;
		strap = 1'b1;
		repeat (3) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(8'(active), 8'h01);
		end_sim();
	end
endmodule
